// ==== src/ebcd_cfg.svh ====
// constants of the external bus control block
// assumes a 32-bit word-addressed space and a 64-bit data bus
`ifndef EBCD_CFG_SVH
`define EBCD_CFG_SVH
`define EBCD_RD 2
`define EBCD_WL 1
`define EBCD_WH 0
`define EBCD_BANK0 6'h02
`define EBCD_BANK1 6'h03
`define EBCD_HOST_NONE 4'h0
`define EBCD_INT_SPACE 6'h00
`define EBCD_STRB_IDLE 3'h7
`define EBCD_SETTLE_LAST 4'h9
`define EBCD_RD_WAIT_LAST 4'h2
`define EBCD_HOST_WAIT_LAST 4'h1
`define EBCD_BURST_STEP 32'h00000002
`define EBCD_PIN_W 102
`endif

// ==== src/ebcd_pkg.sv ====
// types shared by both ends of the external bus
// assumes ebcd_cfg.svh holds the numeric constants
package ebcd_pkg;
    typedef logic [31:0] ebcd_addr_t;
    typedef logic [63:0] ebcd_data_t;
    typedef enum logic [1:0] {
        MST_IDLE = 2'h0,
        MST_SETTLE = 2'h1,
        MST_WAIT = 2'h2,
        MST_TURN = 2'h3
    } ebcd_mst_e;
    typedef enum logic [1:0] {
        SLV_IDLE = 2'h0,
        SLV_HOLD = 2'h1,
        SLV_END = 2'h2
    } ebcd_slv_e;
endpackage

// ==== src/ebcd_bus_if.sv ====
// shared pins between the processor end and the host end
// undriven pins resolve to their pull level; strap_n is set by the bench
`timescale 1ns/10ps
interface ebcd_bus_if;
    logic [31:0] d_addr_o, h_addr_o, addr;
    logic [63:0] d_data_o, h_data_o, data;
    logic [2:0] d_strb_n_o, h_strb_n_o, strb_n;
    logic d_burst_indicator_n_o, h_burst_indicator_n_o, burst_indicator_n;
    logic d_ack_o, h_ack_o, ack;
    logic d_addr_oe_n, h_addr_oe_n, d_data_oe_n, h_data_oe_n;
    logic d_ctl_oe_n, h_ctl_oe_n, d_ack_oe_n, h_ack_oe_n;
    logic [1:0] d_bank_n_o, bank_n;
    logic d_hsel_n_o, hsel_n, d_bms_n_o, d_bms_oe_n, bms_n, strap_n;
    assign addr = !d_addr_oe_n ? d_addr_o : !h_addr_oe_n ? h_addr_o : '1;
    assign data = !d_data_oe_n ? d_data_o : !h_data_oe_n ? h_data_o : '1;
    assign strb_n = !d_ctl_oe_n ? d_strb_n_o :
                    !h_ctl_oe_n ? h_strb_n_o : '1;
    assign burst_indicator_n = !d_ctl_oe_n ? d_burst_indicator_n_o :
                    !h_ctl_oe_n ? h_burst_indicator_n_o : 1'b1;
    // acknowledge is pulled up; any driver low wins
    assign ack = (d_ack_oe_n | d_ack_o) & (h_ack_oe_n | h_ack_o);
    assign bank_n = !d_ctl_oe_n ? d_bank_n_o : 2'h3;
    assign hsel_n = !d_ctl_oe_n ? d_hsel_n_o : 1'b1;
    assign bms_n = !d_bms_oe_n ? d_bms_n_o : strap_n;
    modport dev(output d_addr_o, d_data_o, d_strb_n_o, d_burst_indicator_n_o, d_ack_o,
        d_addr_oe_n, d_data_oe_n, d_ctl_oe_n, d_ack_oe_n, d_bank_n_o,
        d_hsel_n_o, d_bms_n_o, d_bms_oe_n,
        input addr, data, strb_n, burst_indicator_n, ack, bms_n);
    modport host(output h_addr_o, h_data_o, h_strb_n_o, h_burst_indicator_n_o, h_ack_o,
        h_addr_oe_n, h_data_oe_n, h_ctl_oe_n, h_ack_oe_n,
        input addr, data, strb_n, burst_indicator_n, ack, bank_n, hsel_n);
endinterface

// ==== src/ebcd_sync.sv ====
// three-stage input synchroniser for a group of pins
// a change is taken once stages two and three agree
`timescale 1ns/10ps
module ebcd_sync #(
    parameter int W = 1
) (
    input wire logic mclk_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] s1_ff, s2_ff, s3_ff, q_ff, nxt_q;
    always_comb begin
        nxt_q = (s2_ff == s3_ff) ? s3_ff : q_ff;
    end
    // no reset: the strap must be sampled while reset is held
    always_ff @(posedge mclk_in) begin
        s1_ff <= d_in;
        s2_ff <= s1_ff;
        s3_ff <= s2_ff;
        q_ff <= nxt_q;
    end
    assign q_out = q_ff;
endmodule // ebcd_sync

// ==== src/ebcd_dev.sv ====
// processor end of the external bus: master cycles out, slave access in
// assumes arbitration outside grants mastership via mst_grant_in
`timescale 1ns/10ps
`include "ebcd_cfg.svh"
module ebcd_dev #(
    parameter int MEM_DEPTH = 64
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    ebcd_bus_if.dev bus,
    input wire logic mst_grant_in,
    input wire logic mst_req_in,
    input wire logic mst_we_in,
    input wire logic mst_long_in,
    input wire logic mst_zone32_in,
    input wire logic mst_sdram_in,
    input wire logic mst_burst_in,
    input wire ebcd_pkg::ebcd_addr_t mst_addr_in,
    input wire ebcd_pkg::ebcd_data_t mst_wdata_in,
    input wire logic boot_done_in,
    output logic mst_ready_out,
    output ebcd_pkg::ebcd_data_t mst_rdata_out,
    output logic mst_rvalid_out,
    output logic eprom_boot_out
);
    import ebcd_pkg::*;
    localparam int IW = $clog2(MEM_DEPTH);
    if (MEM_DEPTH < 2 || MEM_DEPTH > 65536) begin : g_bad_depth
        $error("ebcd_dev: MEM_DEPTH out of range");
    end

    logic [`EBCD_PIN_W-1:0] pin_q;
    ebcd_addr_t s_addr;
    ebcd_data_t s_data;
    logic [2:0] s_strb_n;
    logic s_burst_indicator_n, s_ack, s_bms_n;
    ebcd_sync #(.W(`EBCD_PIN_W)) u_sync (
        .mclk_in(mclk_in),
        .d_in({bus.addr, bus.data, bus.strb_n, bus.burst_indicator_n, bus.ack,
               bus.bms_n}),
        .q_out(pin_q)
    );
    assign {s_addr, s_data, s_strb_n, s_burst_indicator_n, s_ack, s_bms_n} = pin_q;

    ebcd_mst_e st_ff, nxt_st;
    ebcd_slv_e sl_st_ff, nxt_sl_st;
    logic [3:0] cnt_ff, nxt_cnt;
    ebcd_addr_t addr_ff, nxt_addr;
    ebcd_data_t wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;
    logic [2:0] strb_ff, nxt_strb;
    logic [1:0] bank_ff, nxt_bank;
    logic burst_indicator_ff, nxt_burst_indicator, hsel_ff, nxt_hsel, drive_ff, nxt_drive;
    logic rd_ff, nxt_rd, rvalid_ff, nxt_rvalid;

    always_comb begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        nxt_addr = addr_ff;
        nxt_wdata = wdata_ff;
        nxt_rdata = rdata_ff;
        nxt_strb = strb_ff;
        nxt_bank = bank_ff;
        nxt_burst_indicator = burst_indicator_ff;
        nxt_hsel = hsel_ff;
        nxt_drive = drive_ff;
        nxt_rd = rd_ff;
        nxt_rvalid = 1'b0;
        case (st_ff)
            MST_IDLE: begin
                if (mst_grant_in && mst_req_in && sl_st_ff == SLV_IDLE) begin
                    // address, strobes and selects all load on one edge
                    nxt_addr = mst_addr_in;
                    nxt_wdata = mst_wdata_in;
                    nxt_rd = !mst_we_in;
                    nxt_strb[`EBCD_RD] = mst_we_in | mst_sdram_in;
                    nxt_strb[`EBCD_WL] = !(mst_we_in && (mst_zone32_in ||
                        mst_long_in || !mst_addr_in[0]));
                    nxt_strb[`EBCD_WH] = !(mst_we_in && !mst_zone32_in &&
                        (mst_long_in || mst_addr_in[0]));
                    nxt_bank[0] = mst_addr_in[31:26] != `EBCD_BANK0;
                    nxt_bank[1] = mst_addr_in[31:26] != `EBCD_BANK1;
                    nxt_hsel = mst_addr_in[31:28] == `EBCD_HOST_NONE;
                    nxt_burst_indicator = !mst_burst_in;
                    nxt_drive = 1'b1;
                    nxt_cnt = 4'h0;
                    nxt_st = MST_SETTLE;
                end else if (!mst_grant_in) begin
                    nxt_drive = 1'b0;
                    nxt_burst_indicator = 1'b1;
                end
            end
            MST_SETTLE: begin
                // give the slave time to pull acknowledge low
                nxt_cnt = cnt_ff + 4'h1;
                if (cnt_ff == `EBCD_SETTLE_LAST) begin
                    nxt_st = MST_WAIT;
                end
            end
            MST_WAIT: begin
                if (s_ack) begin
                    nxt_rdata = s_data;
                    nxt_rvalid = rd_ff;
                    nxt_strb = `EBCD_STRB_IDLE;
                    // selects hold with the address until the bus is freed
                    nxt_cnt = 4'h0;
                    nxt_st = MST_TURN;
                end
            end
            MST_TURN: begin
                nxt_cnt = cnt_ff + 4'h1;
                if (cnt_ff == `EBCD_SETTLE_LAST) begin
                    // the bus stays held between beats of a burst
                    nxt_drive = !burst_indicator_ff;
                    nxt_st = MST_IDLE;
                end
            end
            default: nxt_st = MST_IDLE;
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            st_ff <= MST_IDLE;
            cnt_ff <= 4'h0;
            addr_ff <= 32'h00000000;
            wdata_ff <= 64'h0000000000000000;
            rdata_ff <= 64'h0000000000000000;
            strb_ff <= `EBCD_STRB_IDLE;
            bank_ff <= 2'h3;
            burst_indicator_ff <= 1'b1;
            hsel_ff <= 1'b1;
            drive_ff <= 1'b0;
            rd_ff <= 1'b0;
            rvalid_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            addr_ff <= nxt_addr;
            wdata_ff <= nxt_wdata;
            rdata_ff <= nxt_rdata;
            strb_ff <= nxt_strb;
            bank_ff <= nxt_bank;
            burst_indicator_ff <= nxt_burst_indicator;
            hsel_ff <= nxt_hsel;
            drive_ff <= nxt_drive;
            rd_ff <= nxt_rd;
            rvalid_ff <= nxt_rvalid;
        end
    end

    // slave side: host or peer reaching internal memory
    logic [3:0] sl_cnt_ff, nxt_sl_cnt;
    ebcd_addr_t sl_addr_ff, nxt_sl_addr, wa;
    ebcd_data_t sl_data_ff, nxt_sl_data;
    logic ack_drv_ff, nxt_ack_drv, ack_o_ff, nxt_ack_o;
    logic dat_drv_ff, nxt_dat_drv, burst_ff, nxt_burst, hit, mem_we;
    ebcd_data_t mem [MEM_DEPTH];

    always_comb begin
        nxt_sl_st = sl_st_ff;
        nxt_sl_cnt = sl_cnt_ff;
        nxt_sl_addr = sl_addr_ff;
        nxt_sl_data = sl_data_ff;
        nxt_ack_drv = ack_drv_ff;
        nxt_ack_o = ack_o_ff;
        nxt_dat_drv = dat_drv_ff;
        nxt_burst = burst_ff;
        mem_we = 1'b0;
        // inside a burst later addresses are ignored
        wa = burst_ff ? sl_addr_ff : s_addr;
        hit = !drive_ff && s_strb_n != `EBCD_STRB_IDLE &&
              (burst_ff || s_addr[31:26] == `EBCD_INT_SPACE);
        case (sl_st_ff)
            SLV_IDLE: begin
                if (drive_ff) begin
                    nxt_burst = 1'b0;
                end else if (hit) begin
                    nxt_sl_addr = wa;
                    if (!s_strb_n[`EBCD_RD]) begin
                        nxt_ack_drv = 1'b1;
                        nxt_ack_o = 1'b0;
                        nxt_sl_cnt = 4'h0;
                        nxt_sl_st = SLV_HOLD;
                    end else begin
                        mem_we = 1'b1;
                        nxt_sl_st = SLV_END;
                    end
                end
            end
            SLV_HOLD: begin
                nxt_sl_cnt = sl_cnt_ff + 4'h1;
                if (sl_cnt_ff == `EBCD_RD_WAIT_LAST) begin
                    nxt_sl_data = mem[sl_addr_ff[IW:1]];
                    nxt_ack_o = 1'b1;
                    nxt_dat_drv = 1'b1;
                    nxt_sl_st = SLV_END;
                end
            end
            SLV_END: begin
                if (s_strb_n == `EBCD_STRB_IDLE) begin
                    nxt_ack_drv = 1'b0;
                    nxt_dat_drv = 1'b0;
                    nxt_burst = !s_burst_indicator_n;
                    nxt_sl_addr = sl_addr_ff + `EBCD_BURST_STEP;
                    nxt_sl_st = SLV_IDLE;
                end
            end
            default: nxt_sl_st = SLV_IDLE;
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            sl_st_ff <= SLV_IDLE;
            sl_cnt_ff <= 4'h0;
            sl_addr_ff <= 32'h00000000;
            sl_data_ff <= 64'h0000000000000000;
            ack_drv_ff <= 1'b0;
            ack_o_ff <= 1'b1;
            dat_drv_ff <= 1'b0;
            burst_ff <= 1'b0;
        end else begin
            sl_st_ff <= nxt_sl_st;
            sl_cnt_ff <= nxt_sl_cnt;
            sl_addr_ff <= nxt_sl_addr;
            sl_data_ff <= nxt_sl_data;
            ack_drv_ff <= nxt_ack_drv;
            ack_o_ff <= nxt_ack_o;
            dat_drv_ff <= nxt_dat_drv;
            burst_ff <= nxt_burst;
        end
    end

    // each write strobe enables its own half of the word
    always_ff @(posedge mclk_in) begin
        if (mem_we && !s_strb_n[`EBCD_WL]) begin
            mem[wa[IW:1]][31:0] <= s_data[31:0];
        end
        if (mem_we && !s_strb_n[`EBCD_WH]) begin
            mem[wa[IW:1]][63:32] <= s_data[63:32];
        end
    end

    // strap is caught on every reset edge; boot select follows it until boot_done_in clears it
    logic eprom_boot_strap_ff, nxt_eprom_boot_strap, boot_act_ff, nxt_boot_act;
    always_comb begin
        nxt_eprom_boot_strap = eprom_boot_strap_ff;
        nxt_boot_act = boot_act_ff & !boot_done_in;
        if (rst_in) begin
            nxt_eprom_boot_strap = !s_bms_n;
            nxt_boot_act = !s_bms_n;
        end
    end
    always_ff @(posedge mclk_in) begin
        eprom_boot_strap_ff <= nxt_eprom_boot_strap;
        boot_act_ff <= nxt_boot_act;
    end

    assign bus.d_addr_o = addr_ff;
    assign bus.d_addr_oe_n = !drive_ff;
    assign bus.d_data_o = dat_drv_ff ? sl_data_ff : wdata_ff;
    assign bus.d_data_oe_n = !(dat_drv_ff || (drive_ff && !rd_ff));
    assign bus.d_strb_n_o = strb_ff;
    assign bus.d_burst_indicator_n_o = burst_indicator_ff;
    assign bus.d_ctl_oe_n = !drive_ff;
    assign bus.d_bank_n_o = bank_ff;
    assign bus.d_hsel_n_o = hsel_ff;
    assign bus.d_ack_o = ack_o_ff;
    assign bus.d_ack_oe_n = !ack_drv_ff;
    assign bus.d_bms_n_o = !boot_act_ff;
    assign bus.d_bms_oe_n = !drive_ff;
    assign mst_ready_out = st_ff == MST_IDLE && mst_grant_in &&
                           sl_st_ff == SLV_IDLE;
    assign mst_rdata_out = rdata_ff;
    assign mst_rvalid_out = rvalid_ff;
    assign eprom_boot_out = eprom_boot_strap_ff;
endmodule // ebcd_dev

// ==== src/ebcd_host.sv ====
// host end of the external bus: masters the processor, serves host space
// assumes arbitration outside grants mastership via h_grant_in
`timescale 1ns/10ps
`include "ebcd_cfg.svh"
module ebcd_host #(
    parameter int MEM_DEPTH = 16
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    ebcd_bus_if.host bus,
    input wire logic h_grant_in,
    input wire logic h_req_in,
    input wire logic h_we_in,
    input wire logic [1:0] h_wmask_in,
    input wire logic h_burst_in,
    input wire ebcd_pkg::ebcd_addr_t h_addr_in,
    input wire ebcd_pkg::ebcd_data_t h_wdata_in,
    output logic h_ready_out,
    output ebcd_pkg::ebcd_data_t h_rdata_out,
    output logic h_rvalid_out
);
    import ebcd_pkg::*;
    localparam int IW = $clog2(MEM_DEPTH);
    if (MEM_DEPTH < 2 || MEM_DEPTH > 65536) begin : g_bad_depth
        $error("ebcd_host: MEM_DEPTH out of range");
    end
    logic [`EBCD_PIN_W-1:0] pin_q;
    ebcd_addr_t s_addr;
    ebcd_data_t s_data;
    logic [2:0] s_strb_n;
    logic s_burst_indicator_n, s_ack, s_hsel_n;
    ebcd_sync #(.W(`EBCD_PIN_W)) u_sync (
        .mclk_in(mclk_in),
        .d_in({bus.addr, bus.data, bus.strb_n, bus.burst_indicator_n, bus.ack,
               bus.hsel_n}),
        .q_out(pin_q)
    );
    assign {s_addr, s_data, s_strb_n, s_burst_indicator_n, s_ack, s_hsel_n} = pin_q;

    ebcd_mst_e st_ff, nxt_st;
    ebcd_slv_e sl_ff, nxt_sl;
    logic [3:0] cnt_ff, nxt_cnt;
    ebcd_addr_t addr_ff, nxt_addr;
    ebcd_data_t wdata_ff, nxt_wdata, rdata_ff, nxt_rdata, sd_ff, nxt_sd;
    logic [2:0] strb_ff, nxt_strb;
    logic burst_indicator_ff, nxt_burst_indicator, drive_ff, nxt_drive, rd_ff, nxt_rd;
    logic rvalid_ff, nxt_rvalid, ackd_ff, nxt_ackd, acko_ff, nxt_acko;
    logic ddrv_ff, nxt_ddrv, mem_we;
    ebcd_data_t mem [MEM_DEPTH];

    always_comb begin
        nxt_st = st_ff;
        nxt_sl = sl_ff;
        nxt_cnt = cnt_ff;
        nxt_addr = addr_ff;
        nxt_wdata = wdata_ff;
        nxt_rdata = rdata_ff;
        nxt_sd = sd_ff;
        nxt_strb = strb_ff;
        nxt_burst_indicator = burst_indicator_ff;
        nxt_drive = drive_ff;
        nxt_rd = rd_ff;
        nxt_rvalid = 1'b0;
        nxt_ackd = ackd_ff;
        nxt_acko = acko_ff;
        nxt_ddrv = ddrv_ff;
        mem_we = 1'b0;
        case (st_ff)
            MST_IDLE: begin
                if (h_grant_in && h_req_in && sl_ff == SLV_IDLE) begin
                    nxt_addr = h_addr_in;
                    nxt_wdata = h_wdata_in;
                    nxt_rd = !h_we_in;
                    nxt_strb = {h_we_in, !(h_we_in && h_wmask_in[0]),
                                !(h_we_in && h_wmask_in[1])};
                    nxt_burst_indicator = !h_burst_in;
                    nxt_drive = 1'b1;
                    nxt_cnt = 4'h0;
                    nxt_st = MST_SETTLE;
                end else if (!h_grant_in) begin
                    nxt_drive = 1'b0;
                    nxt_burst_indicator = 1'b1;
                end
            end
            MST_SETTLE: begin
                nxt_cnt = cnt_ff + 4'h1;
                if (cnt_ff == `EBCD_SETTLE_LAST) begin
                    nxt_st = MST_WAIT;
                end
            end
            MST_WAIT: begin
                if (s_ack) begin
                    nxt_rdata = s_data;
                    nxt_rvalid = rd_ff;
                    nxt_strb = `EBCD_STRB_IDLE;
                    nxt_cnt = 4'h0;
                    nxt_st = MST_TURN;
                end
            end
            MST_TURN: begin
                nxt_cnt = cnt_ff + 4'h1;
                if (cnt_ff == `EBCD_SETTLE_LAST) begin
                    nxt_drive = !burst_indicator_ff;
                    nxt_st = MST_IDLE;
                end
            end
            default: nxt_st = MST_IDLE;
        endcase
        // host-space slave: waits on every access, address taken each beat
        case (sl_ff)
            SLV_IDLE: begin
                if (!drive_ff && !s_hsel_n && s_strb_n != `EBCD_STRB_IDLE) begin
                    nxt_ackd = 1'b1;
                    nxt_acko = 1'b0;
                    mem_we = s_strb_n[`EBCD_RD];
                    nxt_cnt = 4'h0;
                    nxt_sl = SLV_HOLD;
                end
            end
            SLV_HOLD: begin
                nxt_cnt = cnt_ff + 4'h1;
                if (cnt_ff == `EBCD_HOST_WAIT_LAST) begin
                    nxt_sd = mem[s_addr[IW:1]];
                    nxt_acko = 1'b1;
                    nxt_ddrv = !s_strb_n[`EBCD_RD];
                    nxt_sl = SLV_END;
                end
            end
            SLV_END: begin
                if (s_strb_n == `EBCD_STRB_IDLE) begin
                    nxt_ackd = 1'b0;
                    nxt_ddrv = 1'b0;
                    nxt_sl = SLV_IDLE;
                end
            end
            default: nxt_sl = SLV_IDLE;
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            st_ff <= MST_IDLE;
            sl_ff <= SLV_IDLE;
            cnt_ff <= 4'h0;
            addr_ff <= 32'h00000000;
            wdata_ff <= 64'h0000000000000000;
            rdata_ff <= 64'h0000000000000000;
            sd_ff <= 64'h0000000000000000;
            strb_ff <= `EBCD_STRB_IDLE;
            burst_indicator_ff <= 1'b1;
            drive_ff <= 1'b0;
            rd_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            ackd_ff <= 1'b0;
            acko_ff <= 1'b1;
            ddrv_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            sl_ff <= nxt_sl;
            cnt_ff <= nxt_cnt;
            addr_ff <= nxt_addr;
            wdata_ff <= nxt_wdata;
            rdata_ff <= nxt_rdata;
            sd_ff <= nxt_sd;
            strb_ff <= nxt_strb;
            burst_indicator_ff <= nxt_burst_indicator;
            drive_ff <= nxt_drive;
            rd_ff <= nxt_rd;
            rvalid_ff <= nxt_rvalid;
            ackd_ff <= nxt_ackd;
            acko_ff <= nxt_acko;
            ddrv_ff <= nxt_ddrv;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (mem_we && !s_strb_n[`EBCD_WL]) begin
            mem[s_addr[IW:1]][31:0] <= s_data[31:0];
        end
        if (mem_we && !s_strb_n[`EBCD_WH]) begin
            mem[s_addr[IW:1]][63:32] <= s_data[63:32];
        end
    end

    assign bus.h_addr_o = addr_ff;
    assign bus.h_addr_oe_n = !drive_ff;
    assign bus.h_data_o = ddrv_ff ? sd_ff : wdata_ff;
    assign bus.h_data_oe_n = !(ddrv_ff || (drive_ff && !rd_ff));
    assign bus.h_strb_n_o = strb_ff;
    assign bus.h_burst_indicator_n_o = burst_indicator_ff;
    assign bus.h_ctl_oe_n = !drive_ff;
    assign bus.h_ack_o = acko_ff;
    assign bus.h_ack_oe_n = !ackd_ff;
    assign h_ready_out = st_ff == MST_IDLE && h_grant_in && sl_ff == SLV_IDLE;
    assign h_rdata_out = rdata_ff;
    assign h_rvalid_out = rvalid_ff;
endmodule // ebcd_host

// ==== tb/ebcd_bus_assertions.sv ====
// pin-level checks on the shared bus between the two ends
// assumes one clock and a synchronous active-high reset
`timescale 1ns/10ps
module ebcd_bus_assertions (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic [31:0] addr,
    input wire logic [2:0] strb_n,
    input wire logic [1:0] bank_n,
    input wire logic hsel_n,
    input wire logic d_addr_oe_n,
    input wire logic d_data_oe_n,
    input wire logic d_ctl_oe_n,
    input wire logic h_ctl_oe_n,
    input wire logic d_ack_oe_n
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    // selects only mean something while this end drives address and controls
    wire logic dm = !d_ctl_oe_n && !d_addr_oe_n;
    wire logic [5:0] top = addr[31:26];
    bank_zero_a: assert property (
        dm && top == 6'h02 |-> bank_n == 2'h2) else $error("bank 0 wrong");
    bank_one_a: assert property (
        dm && top == 6'h03 |-> bank_n == 2'h1) else $error("bank 1 wrong");
    host_select_a: assert property (
        dm |-> hsel_n == (top[5:2] == 4'h0)) else $error("host select wrong");
    ctl_with_addr_a: assert property (
        $fell(d_ctl_oe_n) |-> $fell(d_addr_oe_n)) else $error("ctl not w addr");
    sel_with_addr_a: assert property (
        !d_ctl_oe_n && !$past(d_ctl_oe_n) && $changed({bank_n, hsel_n})
        |-> $changed(addr)) else $error("select moved alone");
    one_master_a: assert property (
        d_ctl_oe_n || h_ctl_oe_n) else $error("two strobe drivers");
    read_no_data_a: assert property (
        !d_ctl_oe_n && !strb_n[2] |-> d_data_oe_n) else $error("data on read");
    write_data_a: assert property (
        !d_ctl_oe_n && strb_n[1:0] != 2'h3 |-> !d_data_oe_n)
        else $error("no data on write");
    slave_write_ack_a: assert property (
        d_ctl_oe_n && strb_n[1:0] != 2'h3 |-> d_ack_oe_n)
        else $error("ack driven on slave write");
    read_strobe_hold_a: assert property (
        $fell(strb_n[2]) && !d_ctl_oe_n |-> !strb_n[2] [*8])
        else $error("read strobe too short");
    cover property (!d_ack_oe_n);
    cover property (dm && top == 6'h03);
    cover property (!h_ctl_oe_n && !strb_n[2]);
endmodule // ebcd_bus_assertions

// ==== tb/tb.sv ====
// random and corner traffic between the processor end and the host end
// assumes the host end serves host space and the strap is pulled low
`timescale 1ns/10ps
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin \
    bad_count++; $display("wrong value %s exp %h got %h", n, e, s); end end
module tb;
    import ebcd_pkg::*;
    logic mclk_in = 0, rst_in = 1, dg = 0, hg = 0, dreq = 0, hreq = 0;
    logic we = 0, lng = 0, z32 = 0, sd = 0, burst_indicator = 0, bdone = 0;
    logic [1:0] msk = 0;
    ebcd_addr_t ad = 0;
    ebcd_data_t wd = 0, rd;
    wire logic dready, hready, drv, hrv, eprom_boot_strap;
    wire ebcd_data_t drd, hrd;
    int bad_count = 0, n_tests = 0, cyc = 0;
    ebcd_bus_if bus ();
    ebcd_dev i_ebcd_dev (.mclk_in, .rst_in, .bus(bus.dev),
        .mst_grant_in(dg), .mst_req_in(dreq), .mst_we_in(we),
        .mst_long_in(lng), .mst_zone32_in(z32), .mst_sdram_in(sd),
        .mst_burst_in(burst_indicator), .mst_addr_in(ad), .mst_wdata_in(wd),
        .boot_done_in(bdone), .mst_ready_out(dready),
        .mst_rdata_out(drd), .mst_rvalid_out(drv), .eprom_boot_out(eprom_boot_strap));
    ebcd_host i_ebcd_host (.mclk_in, .rst_in, .bus(bus.host),
        .h_grant_in(hg), .h_req_in(hreq), .h_we_in(we), .h_wmask_in(msk),
        .h_burst_in(burst_indicator), .h_addr_in(ad), .h_wdata_in(wd),
        .h_ready_out(hready), .h_rdata_out(hrd), .h_rvalid_out(hrv));
    ebcd_bus_assertions i_ebcd_bus_assertions (.mclk_in, .rst_in,
        .addr(bus.addr), .strb_n(bus.strb_n), .bank_n(bus.bank_n),
        .hsel_n(bus.hsel_n), .d_addr_oe_n(bus.d_addr_oe_n),
        .d_data_oe_n(bus.d_data_oe_n), .d_ctl_oe_n(bus.d_ctl_oe_n),
        .h_ctl_oe_n(bus.h_ctl_oe_n), .d_ack_oe_n(bus.d_ack_oe_n));
    initial forever #5 mclk_in = ~mclk_in;
    function automatic ebcd_data_t merge(logic [1:0] m, ebcd_data_t o, n);
        return {m[1] ? n[63:32] : o[63:32], m[0] ? n[31:0] : o[31:0]};
    endfunction
    task automatic test_done();
        if (bad_count == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            bad_count++;
            test_done();
        end
    end
    // md = {burst, long, zone32, sdram, mask}; ready is read mid-cycle
    // so the take edge never races the design's own updates
    task automatic xfer(input logic h, w, input ebcd_addr_t a,
        input ebcd_data_t d, input logic [5:0] md);
        logic r;
        while ((dg && dready !== 1'b1) || (hg && hready !== 1'b1))
            @(negedge mclk_in);
        @(posedge mclk_in);
        {dg, hg, we, ad, wd} <= {!h, h, w, a, d};
        {burst_indicator, lng, z32, sd, msk} <= md;
        {dreq, hreq} <= {!h, h};
        do begin
            @(negedge mclk_in);
            r = h ? hready : dready;
            @(posedge mclk_in);
        end while (r !== 1'b1);
        {dreq, hreq} <= 2'h0;
        if (!w) begin
            do @(negedge mclk_in); while ((h ? hrv : drv) !== 1'b1);
            rd = h ? hrd : drd;
        end
    endtask
    initial begin
        ebcd_addr_t a;
        ebcd_data_t d1, d2;
        logic [1:0] m;
        bus.strap_n = 1'b0;
        void'($urandom(37));
        repeat (12) @(posedge mclk_in);
        rst_in <= 0;
        @(posedge mclk_in);
        `CHK("boot strap", 1'b1, eprom_boot_strap)
        for (int i = 0; i < 9; i++) begin
            a = 32'(($urandom % 16) * 2);
            d1 = {$urandom, $urandom};
            d2 = {$urandom, $urandom};
            xfer(1, 1, a, d1, 6'h03);
            xfer(1, 1, a, d2, {4'h0, 2'(i % 3 + 1)});
            xfer(1, 0, a, 0, 6'h00);
            `CHK("slave mem", merge(2'(i % 3 + 1), d1, d2), rd)
        end
        xfer(1, 1, 32'h00000010, d1, 6'h23);
        xfer(1, 1, 32'h00000010, d2, 6'h03);
        xfer(1, 0, 32'h00000010, 0, 6'h00);
        `CHK("burst first", d1, rd)
        xfer(1, 0, 32'h00000012, 0, 6'h00);
        `CHK("burst step", d2, rd)
        for (int i = 0; i < 6; i++) begin
            a = 32'h10000000 | 32'(($urandom % 8) * 2);
            d1 = {$urandom, $urandom};
            d2 = {$urandom, $urandom};
            xfer(0, 1, a, d1, 6'h10);
            xfer(0, 1, a | 32'(i % 2), d2,
                i % 3 == 0 ? 6'h00 : i % 3 == 1 ? 6'h08 : 6'h10);
            xfer(0, 0, a, 0, 6'h00);
            m = i % 3 == 2 ? 2'h3 : i % 6 == 3 ? 2'h2 : 2'h1;
            `CHK("host mem", merge(m, d1, d2), rd)
            `CHK("boot select", 1'b0, bus.bms_n)
        end
        for (int i = 0; i < 4; i++) begin
            xfer(0, 0, {5'h01, i[0], 26'h0000ABC}, 0, {3'h0, i[1], 2'h0});
            `CHK("float read", 64'hFFFFFFFFFFFFFFFF, rd)
        end
        bdone <= 1;
        xfer(0, 0, 32'h08000000, 0, 6'h00);
        `CHK("boot select", 1'b1, bus.bms_n)
        test_done();
    end
endmodule // tb
